// ### rtl/tfoe_pkg.sv
// constants and types of the timer flag and compare output enable block
// assumes one 100 MHz clock and an 8-bit register port with 3 address bits
package tfoe_pkg;

    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W  = 16;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_ENABLES = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_FLAGS   = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_OUT_EN  = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 3'h3;

    // values after reset
    localparam logic [DATA_W-1:0] RST_ENABLES = 8'hF8;
    localparam logic [DATA_W-1:0] RST_FLAGS   = 8'hF8;
    localparam logic [DATA_W-1:0] RST_OUT_EN  = 8'hF0;
    localparam logic [DATA_W-1:0] RST_CTRL    = 8'h00;
    localparam logic [DATA_W-1:0] RD_UNMAPPED = 8'h00;

    // unused upper bits, read back as ones
    localparam logic [DATA_W-1:0] FLAG_PAD_ONES = 8'hF8;
    localparam logic [DATA_W-1:0] OE_PAD_ONES   = 8'hF0;

    // field positions
    localparam int unsigned BIT_WRAP    = 2;
    localparam int unsigned BIT_EVT_B   = 1;
    localparam int unsigned BIT_EVT_A   = 0;
    localparam int unsigned OE_B_LSB    = 2;
    localparam int unsigned OE_A_LSB    = 0;
    localparam int unsigned EDGE_B_LSB  = 2;
    localparam int unsigned EDGE_A_LSB  = 0;
    localparam int unsigned PHASE_BIT   = 4;
    localparam int unsigned NUM_FLAGS   = 3;
    localparam int unsigned CTRL_W      = 5;

    // counter end points
    localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

    // compare output action per general register
    typedef enum logic [1:0] {
        OUT_NONE = 2'h0,
        OUT_LOW  = 2'h1,
        OUT_HIGH = 2'h2,
        OUT_RSVD = 2'h3
    } tfoe_out_sel_t;

endpackage

// ### rtl/tfoe_evt_if.sv
// counter facing signals shared by the top and the event detector
// assumes all signals live on the one system clock
`timescale 1ns/1ns
`default_nettype none
interface tfoe_evt_if;
    import tfoe_pkg::*;
    logic [CNT_W-1:0] count;
    logic             step;
    logic [CNT_W-1:0] gr_a;
    logic [CNT_W-1:0] gr_b;
    logic             phase_mode;
    logic             cmp_mode_a;
    logic             cmp_mode_b;
    logic             wrap_evt;
    logic             match_a;
    logic             match_b;

    modport ctrl (output count, step, gr_a, gr_b, phase_mode, cmp_mode_a, cmp_mode_b,
                  input wrap_evt, match_a, match_b);
    modport det  (input count, step, gr_a, gr_b, phase_mode, cmp_mode_a, cmp_mode_b,
                  output wrap_evt, match_a, match_b);
endinterface
`default_nettype wire

// ### rtl/tfoe_event_det.sv
// wrap and compare match detector for one 16-bit timer channel
// assumes step pulses once in the cycle the counter takes a new value
`timescale 1ns/1ns
`default_nettype none
module tfoe_event_det
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // counter side
    tfoe_evt_if.det   ev
);
    import tfoe_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] prev_count;
    } tfoe_det_t;

    tfoe_det_t det_reg;
    tfoe_det_t det_next;

    always_comb begin
        det_next = det_reg;
        if (ev.step) begin
            det_next.prev_count = ev.count;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            det_reg <= '{prev_count: CNT_ZERO};
        end else begin
            det_reg <= det_next;
        end
    end

    // up wrap always; down wrap only while phase counting
    assign ev.wrap_evt = ev.step &&
        ((det_reg.prev_count == CNT_MAX && ev.count == CNT_ZERO) ||
         (ev.phase_mode && det_reg.prev_count == CNT_ZERO
          && ev.count == CNT_MAX));

    // match counts only on a fresh counter value, not while it sits still
    assign ev.match_b = ev.step && ev.cmp_mode_b && (ev.count == ev.gr_b);
    assign ev.match_a = ev.step && ev.cmp_mode_a && (ev.count == ev.gr_a);
endmodule
`default_nettype wire

// ### rtl/tfoe_top.sv
// event flags, interrupt requests and compare output enables of one timer channel
// assumes counter, general registers and capture pulses come from logic on clk
`timescale 1ns/1ns
`default_nettype none
module tfoe_top
(
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // register port
    input  wire logic [tfoe_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [tfoe_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [tfoe_pkg::DATA_W-1:0] reg_rdata,
    // counter and general registers
    input  wire logic [tfoe_pkg::CNT_W-1:0]  count,
    input  wire logic                        count_step,
    input  wire logic [tfoe_pkg::CNT_W-1:0]  general_reg_a,
    input  wire logic [tfoe_pkg::CNT_W-1:0]  general_reg_b,
    input  wire logic                        capture_a,
    input  wire logic                        capture_b,
    // transfer controller service
    input  wire logic                        transfer_controller_ack_a,
    input  wire logic                        transfer_controller_ack_b,
    // interrupt requests
    output logic                             wrap_irq,
    output logic                             event_irq_a,
    output logic                             event_irq_b,
    // compare output pins
    output logic                             cmp_pin_a,
    output logic                             cmp_pin_a_oe,
    output logic                             cmp_pin_b,
    output logic                             cmp_pin_b_oe
);
    import tfoe_pkg::*;

    typedef struct packed {
        logic [NUM_FLAGS-1:0] enables;
        logic [NUM_FLAGS-1:0] flags;
        logic [NUM_FLAGS-1:0] armed;
        logic [3:0]           out_en;
        logic [CTRL_W-1:0]    ctrl;
        logic [DATA_W-1:0]    rdata;
        logic                 pin_a;
        logic                 pin_b;
    } tfoe_state_t;

    tfoe_state_t st_reg;
    tfoe_state_t st_next;

    tfoe_evt_if ev ();

    // compare mode means both edge select bits are zero
    function automatic logic tfoe_is_cmp(input logic [1:0] edge_sel);
        return edge_sel == 2'h0;
    endfunction

    // only the two documented codes drive the pin; 11 is held off
    function automatic logic tfoe_drives(input logic [1:0] sel, input logic cmp);
        logic drv;
        drv = 1'b0;
        if (cmp) begin
            unique case (tfoe_out_sel_t'(sel))
                OUT_LOW:  drv = 1'b1;
                OUT_HIGH: drv = 1'b1;
                OUT_NONE: drv = 1'b0;
                OUT_RSVD: drv = 1'b0;
            endcase
        end
        return drv;
    endfunction

    // new pin level on a match; keeps the old level otherwise
    function automatic logic tfoe_pin_next(input logic [1:0] sel,
                                           input logic       cmp,
                                           input logic       hit,
                                           input logic       cur);
        logic lvl;
        lvl = cur;
        if (hit && tfoe_drives(sel, cmp)) begin
            lvl = (tfoe_out_sel_t'(sel) == OUT_HIGH);
        end
        return lvl;
    endfunction

    logic [1:0]           edge_sel_a;
    logic [1:0]           edge_sel_b;
    logic [1:0]           out_sel_a;
    logic [1:0]           out_sel_b;
    logic                 cmp_mode_a;
    logic                 cmp_mode_b;
    logic [NUM_FLAGS-1:0] hw_set;
    logic [NUM_FLAGS-1:0] sw_clr;
    logic [NUM_FLAGS-1:0] dtc_clr;
    logic [DATA_W-1:0]    rd_mux;
    logic                 wr_flags;
    logic                 rd_flags;

    assign edge_sel_a = st_reg.ctrl[EDGE_A_LSB +: 2];
    assign edge_sel_b = st_reg.ctrl[EDGE_B_LSB +: 2];
    assign out_sel_a  = st_reg.out_en[OE_A_LSB +: 2];
    assign out_sel_b  = st_reg.out_en[OE_B_LSB +: 2];
    assign cmp_mode_a = tfoe_is_cmp(edge_sel_a);
    assign cmp_mode_b = tfoe_is_cmp(edge_sel_b);
    assign wr_flags   = reg_wr && (reg_addr == OFS_FLAGS);
    assign rd_flags   = reg_rd && (reg_addr == OFS_FLAGS);

    assign ev.count      = count;
    assign ev.step       = count_step;
    assign ev.gr_a       = general_reg_a;
    assign ev.gr_b       = general_reg_b;
    assign ev.phase_mode = st_reg.ctrl[PHASE_BIT];
    assign ev.cmp_mode_a = cmp_mode_a;
    assign ev.cmp_mode_b = cmp_mode_b;

    tfoe_event_det u_det (
        .clk   (clk),
        .rst_n (rst_n),
        .ev    (ev.det)
    );

    // captures only count while the register is set up for capture
    always_comb begin
        hw_set            = '0;
        hw_set[BIT_WRAP]  = ev.wrap_evt;
        hw_set[BIT_EVT_B] = ev.match_b || (capture_b && !cmp_mode_b);
        hw_set[BIT_EVT_A] = ev.match_a || (capture_a && !cmp_mode_a);
    end

    // a write clears only bits that were seen as one and are written zero
    always_comb begin
        sw_clr = '0;
        if (wr_flags) begin
            sw_clr = st_reg.armed & ~reg_wdata[NUM_FLAGS-1:0];
        end
    end

    always_comb begin
        dtc_clr            = '0;
        dtc_clr[BIT_EVT_B] = transfer_controller_ack_b;
        dtc_clr[BIT_EVT_A] = transfer_controller_ack_a;
    end

    always_comb begin
        unique case (reg_addr)
            OFS_ENABLES: rd_mux = RST_ENABLES | DATA_W'(st_reg.enables);
            OFS_FLAGS:   rd_mux = FLAG_PAD_ONES | DATA_W'(st_reg.flags);
            OFS_OUT_EN:  rd_mux = OE_PAD_ONES | DATA_W'(st_reg.out_en);
            OFS_CTRL:    rd_mux = DATA_W'(st_reg.ctrl);
            default:     rd_mux = RD_UNMAPPED;
        endcase
    end

    always_comb begin
        st_next = st_reg;

        // set wins: it is ored in after every clear
        st_next.flags = (st_reg.flags & ~sw_clr & ~dtc_clr) | hw_set;

        // a read of the flags arms the bits it returned as one;
        // a write to the flags in a cycle without a flags read consumes the sequence
        if (rd_flags) begin
            st_next.armed = st_reg.flags;
        end else if (wr_flags) begin
            st_next.armed = '0;
        end
        st_next.armed = st_next.armed & st_next.flags;

        if (reg_wr) begin
            unique case (reg_addr)
                OFS_ENABLES: st_next.enables = reg_wdata[NUM_FLAGS-1:0];
                OFS_OUT_EN:  st_next.out_en  = reg_wdata[3:0];
                OFS_CTRL:    st_next.ctrl    = reg_wdata[CTRL_W-1:0];
                default: ;
            endcase
        end

        // read data stands only in the cycle after the strobe
        st_next.rdata = reg_rd ? rd_mux : RD_UNMAPPED;

        st_next.pin_b = tfoe_pin_next(out_sel_b, cmp_mode_b, ev.match_b,
                                      st_reg.pin_b);
        st_next.pin_a = tfoe_pin_next(out_sel_a, cmp_mode_a, ev.match_a,
                                      st_reg.pin_a);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg.enables <= RST_ENABLES[NUM_FLAGS-1:0];
            st_reg.flags   <= RST_FLAGS[NUM_FLAGS-1:0];
            st_reg.armed   <= '0;
            st_reg.out_en  <= RST_OUT_EN[3:0];
            st_reg.ctrl    <= RST_CTRL[CTRL_W-1:0];
            st_reg.rdata   <= RD_UNMAPPED;
            st_reg.pin_a   <= 1'b0;
            st_reg.pin_b   <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;

    // requests follow the registered flags and enables
    assign wrap_irq    = st_reg.flags[BIT_WRAP] && st_reg.enables[BIT_WRAP];
    assign event_irq_b = st_reg.flags[BIT_EVT_B] && st_reg.enables[BIT_EVT_B];
    assign event_irq_a = st_reg.flags[BIT_EVT_A] && st_reg.enables[BIT_EVT_A];

    // enable drops at once when a register leaves compare mode
    assign cmp_pin_a    = st_reg.pin_a;
    assign cmp_pin_b    = st_reg.pin_b;
    assign cmp_pin_a_oe = tfoe_drives(out_sel_a, cmp_mode_a);
    assign cmp_pin_b_oe = tfoe_drives(out_sel_b, cmp_mode_b);
endmodule
`default_nettype wire

// ### tb/tfoe_checker.sv
// port assertions of the timer flag and compare output enable block
// assumes it is bound into tfoe_top, one clock, async active-low reset
`timescale 1ns/1ns
`default_nettype none
module tfoe_checker
(
    // clock and reset
    input wire logic                        clk,
    input wire logic                        rst_n,
    // register port
    input wire logic [tfoe_pkg::ADDR_W-1:0] reg_addr,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [tfoe_pkg::DATA_W-1:0] reg_rdata,
    // counter and events
    input wire logic [tfoe_pkg::CNT_W-1:0]  count,
    input wire logic                        count_step,
    input wire logic [tfoe_pkg::CNT_W-1:0]  general_reg_a,
    input wire logic [tfoe_pkg::CNT_W-1:0]  general_reg_b,
    input wire logic                        capture_a,
    input wire logic                        capture_b,
    input wire logic                        transfer_controller_ack_a,
    input wire logic                        transfer_controller_ack_b,
    // outputs
    input wire logic                        wrap_irq,
    input wire logic                        event_irq_a,
    input wire logic                        event_irq_b,
    input wire logic                        cmp_pin_a,
    input wire logic                        cmp_pin_b
);
    import tfoe_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_pad_f; reg_rd && reg_addr == OFS_FLAGS |=> reg_rdata[7:3] == 5'h1F; endproperty
    a_pad_f: assert property (p_pad_f) else $error("flag pad bits");
    property p_pad_o; reg_rd && reg_addr == OFS_OUT_EN |=> reg_rdata[7:4] == 4'hF; endproperty
    a_pad_o: assert property (p_pad_o) else $error("out enable pad bits");
    property p_irq_a; $rose(event_irq_a) |-> $past(count_step || capture_a || reg_wr); endproperty
    a_irq_a: assert property (p_irq_a) else $error("irq a without cause");
    property p_irq_w; $rose(wrap_irq) |-> $past(count_step || reg_wr); endproperty
    a_irq_w: assert property (p_irq_w) else $error("wrap irq without cause");
    property p_nowr; !event_irq_b && reg_wr && reg_addr == OFS_FLAGS && !count_step
        && !capture_b |=> !event_irq_b; endproperty
    a_nowr: assert property (p_nowr) else $error("write set flag b");
    property p_ack_a; transfer_controller_ack_a && !count_step && !capture_a |=> !event_irq_a;
    endproperty
    a_ack_a: assert property (p_ack_a) else $error("ack a kept flag");
    property p_ack_b; transfer_controller_ack_b && !count_step && !capture_b |=> !event_irq_b;
    endproperty
    a_ack_b: assert property (p_ack_b) else $error("ack b kept flag");
    property p_pin_a; $changed(cmp_pin_a) |-> $past(count_step && count == general_reg_a);
    endproperty
    a_pin_a: assert property (p_pin_a) else $error("pin a moved without match");
    property p_pin_b; $changed(cmp_pin_b) |-> $past(count_step && count == general_reg_b);
    endproperty
    a_pin_b: assert property (p_pin_b) else $error("pin b moved without match");
endmodule
bind tfoe_top tfoe_checker u_chk (
    .clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .count, .count_step,
    .general_reg_a, .general_reg_b, .capture_a, .capture_b,
    .transfer_controller_ack_a, .transfer_controller_ack_b,
    .wrap_irq, .event_irq_a, .event_irq_b, .cmp_pin_a, .cmp_pin_b
);
`default_nettype wire

// ### tb/timer_flag_and_output_enable_test.sv
// self-checking bench of the timer flag and compare output enable block
// assumes the bench alone drives registers, counter and event pulses
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module timer_flag_and_output_enable_test;
    import tfoe_pkg::*;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic [CNT_W-1:0]  cnt = '0;
    logic [CNT_W-1:0]  gra = 16'h0010;
    logic [CNT_W-1:0]  grb = 16'h0020;
    // ack_b, ack_a, capture_b, capture_a, step
    logic [4:0]        ev_v = '0;
    logic [DATA_W-1:0] rdata;
    logic              iw, ia, ib, pa, pa_oe, pb, pb_oe;
    int                n_errors = 0;
    int                samples_checked = 0;
    tfoe_top uut (
        .clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .count(cnt), .count_step(ev_v[0]),
        .general_reg_a(gra), .general_reg_b(grb), .capture_a(ev_v[1]), .capture_b(ev_v[2]),
        .transfer_controller_ack_a(ev_v[3]), .transfer_controller_ack_b(ev_v[4]),
        .wrap_irq(iw), .event_irq_a(ia), .event_irq_b(ib),
        .cmp_pin_a(pa), .cmp_pin_a_oe(pa_oe), .cmp_pin_b(pb), .cmp_pin_b_oe(pb_oe)
    );
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic final_report;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask
    task automatic evt(input logic [4:0] e, input logic [CNT_W-1:0] c);
        @(posedge clk);
        ev_v <= e;
        cnt <= c;
        @(posedge clk);
        ev_v <= '0;
        #1;
    endtask
    task automatic t_regs;
        rreg(OFS_ENABLES, RST_ENABLES);
        rreg(OFS_FLAGS, RST_FLAGS);
        rreg(OFS_OUT_EN, RST_OUT_EN);
        rreg(OFS_CTRL, RST_CTRL);
        rreg(3'h5, RD_UNMAPPED);
        wreg(OFS_FLAGS, 8'hFF);
        rreg(OFS_FLAGS, 8'hF8);
        wreg(OFS_ENABLES, 8'h07);
        rreg(OFS_ENABLES, 8'hFF);
        wreg(OFS_OUT_EN, 8'h0A);
        rreg(OFS_OUT_EN, 8'hFA);
    endtask
    task automatic t_cmp;
        evt(5'h01, gra);
        `CHK({ia, pa, pa_oe}, 3'b111)
        evt(5'h01, grb);
        `CHK({ib, pb, pb_oe}, 3'b111)
        wreg(OFS_OUT_EN, 8'h0F);
        `CHK({pa_oe, pb_oe}, 2'b00)
        evt(5'h01, gra);
        `CHK(pa, 1'b1)
        wreg(OFS_OUT_EN, 8'h05);
        wreg(OFS_CTRL, 8'h05);
        `CHK({pa_oe, pb_oe}, 2'b00)
        evt(5'h01, grb);
        `CHK(pb, 1'b1)
        wreg(OFS_CTRL, 8'h00);
        evt(5'h01, grb);
        `CHK(pb, 1'b0)
        evt(5'h01, gra);
        `CHK(pa, 1'b0)
        // reserved code must not drive the low pin high either
        wreg(OFS_OUT_EN, 8'h0F);
        evt(5'h01, gra);
        `CHK(pa, 1'b0)
        rreg(OFS_FLAGS, 8'hFB);
        wreg(OFS_FLAGS, 8'hFE);
        rreg(OFS_FLAGS, 8'hFA);
        // write without a fresh read must not clear b
        wreg(OFS_FLAGS, 8'hFE);
        wreg(OFS_FLAGS, 8'hF8);
        rreg(OFS_FLAGS, 8'hFA);
        wreg(OFS_ENABLES, 8'h05);
        `CHK({ia, ib}, 2'b00)
        wreg(OFS_ENABLES, 8'h07);
        `CHK({ia, ib}, 2'b01)
    endtask
    task automatic t_evt;
        wreg(OFS_CTRL, 8'h05);
        evt(5'h10, cnt);
        `CHK(ib, 1'b0)
        evt(5'h02, cnt);
        `CHK(ia, 1'b1)
        evt(5'h08, cnt);
        `CHK(ia, 1'b0)
        evt(5'h0A, cnt);
        `CHK(ia, 1'b1)
        evt(5'h04, cnt);
        `CHK(ib, 1'b1)
        evt(5'h18, cnt);
        `CHK({ia, ib}, 2'b00)
    endtask
    task automatic t_wrap;
        wreg(OFS_CTRL, 8'h10);
        evt(5'h01, 16'h0000);
        evt(5'h01, 16'hFFFF);
        `CHK(iw, 1'b1)
        rreg(OFS_FLAGS, 8'hFC);
        wreg(OFS_FLAGS, 8'hFB);
        `CHK(iw, 1'b0)
        wreg(OFS_CTRL, 8'h00);
        wreg(OFS_ENABLES, 8'h03);
        evt(5'h01, 16'h0000);
        `CHK(iw, 1'b0)
        rreg(OFS_FLAGS, 8'hFC);
        wreg(OFS_ENABLES, 8'h07);
        `CHK(iw, 1'b1)
        wreg(OFS_FLAGS, 8'hFB);
        evt(5'h01, 16'hFFFF);
        `CHK(iw, 1'b0)
    endtask
    initial begin
        repeat (16) @(posedge clk);
        `CHK({iw, ia, ib, pa, pb, pa_oe, pb_oe, rdata}, 15'h0000)
        rst_n <= 1'b1;
        t_regs;
        t_cmp;
        t_evt;
        t_wrap;
        final_report;
    end
    // tests need about 116 cycles; this allows over eighty times that
    initial begin
        #100000;
        n_errors++;
        final_report;
    end
endmodule
`default_nettype wire
